// ### rtl/cache_ram.sv
module cache_ram
	import cache_pkg::*;
#(
	parameter int W = 20,
	parameter int D = 128,
	parameter int AW = 7
) (
	input wire logic clk_sys, // System clock
	input wire logic we, // Write enable
	input wire logic [AW-1:0] addr, // Word address
	input wire logic [W-1:0] wdata, // Write data
	output logic [W-1:0] rdata // Registered read data
);

	logic [W-1:0] mem [D];

	// Read data is registered so the lookup compares on the next edge
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule // cache_ram

// ### rtl/primary_cache.sv
module primary_cache
	import cache_pkg::*;
#(
	parameter logic [7:0] FUSE_OK = 8'hFF
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire cpu_req_t req, // Core reference
	input wire logic req_valid, // Reference present
	output logic req_ready, // Reference may be taken
	output logic rsp_valid, // One-cycle answer strobe
	output logic [31:0] rsp_data, // Read longword
	output logic par_err, // One-cycle cache parity error
	input wire ipr_cmd_t ipr, // Processor register access
	output logic [31:0] ipr_rdata, // Processor register read data
	output logic mem_req, // External bus cycle request
	output mem_cmd_t mem_cmd, // External bus cycle
	input wire logic mem_ack, // External cycle done
	input wire logic [63:0] mem_rdata // Quadword read from memory
);

	typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_MEM} state_t;

	state_t state, next_state;
	cpu_req_t cur, next_cur;
	logic [3:0] cache_control_reg, next_cache_control_reg;
	logic [7:0] bank_en, next_bank_en;
	logic [7:0] bank_hit, next_bank_hit;
	logic [SETS-1:0][ENTRIES-1:0] valid, next_valid;
	logic next_req_ready, next_rsp_valid, next_par_err, next_mem_req;
	logic [31:0] next_rsp_data, next_ipr_rdata;
	mem_cmd_t next_mem_cmd;

	logic [IDX_W-1:0] ram_idx, cidx;
	logic [TAG_W-1:0] ctag;
	logic [TAGRAM_W-1:0] tag_q [SETS];
	logic [DATARAM_W-1:0] lo_q [SETS];
	logic [DATARAM_W-1:0] hi_q [SETS];
	logic [DATARAM_W-1:0] word_q [SETS];
	logic [SETS-1:0] tag_we, lo_we, hi_we, en_eff, hit;
	logic [TAGRAM_W-1:0] tag_wd;
	logic [DATARAM_W-1:0] lo_wd, hi_wd;
	logic [2:0] pri, hit_bank, victim;
	logic in_win, cacheable, dpar_bad;

	assign cidx = cur.addr[IDX_LSB +: IDX_W];
	assign ctag = cur.addr[TAG_LSB +: TAG_W];
	assign ram_idx = (state == ST_IDLE) ? req.addr[IDX_LSB +: IDX_W] : cidx;
	assign en_eff = bank_en & FUSE_OK;
	assign in_win = cache_control_reg[CTRL_DIAG] &&
		cur.addr[ADDR_W-1:12] == DIAG_PAGE;
	assign cacheable = cache_control_reg[CTRL_ENABLE] &&
		!cur.addr[IO_SPACE_BIT];

	genvar g;
	generate
		for (g = 0; g < SETS; g++) begin : g_set
			cache_ram #(.W(TAGRAM_W), .D(ENTRIES), .AW(IDX_W)) u_tag (
				.clk_sys(clk_sys),
				.we(tag_we[g]),
				.addr(ram_idx),
				.wdata(tag_wd),
				.rdata(tag_q[g])
			);
			// Quadword block split into two longword halves
			cache_ram #(.W(DATARAM_W), .D(ENTRIES), .AW(IDX_W)) u_lo (
				.clk_sys(clk_sys),
				.we(lo_we[g]),
				.addr(ram_idx),
				.wdata(lo_wd),
				.rdata(lo_q[g])
			);
			cache_ram #(.W(DATARAM_W), .D(ENTRIES), .AW(IDX_W)) u_hi (
				.clk_sys(clk_sys),
				.we(hi_we[g]),
				.addr(ram_idx),
				.wdata(hi_wd),
				.rdata(hi_q[g])
			);
		end
	endgenerate

	// Per-bank compare; a bad tag parity simply counts as a miss
	always_comb begin
		pri = 3'h0;
		hit_bank = 3'h0;
		victim = 3'h0;
		for (int i = 0; i < SETS; i++) begin
			word_q[i] = cur.addr[2] ? hi_q[i] : lo_q[i];
			hit[i] = en_eff[i] && valid[i][cidx] &&
				tag_q[i][TAG_W-1:0] == ctag &&
				(^tag_q[i][TAG_W-1:0]) == tag_q[i][TAG_W];
		end
		for (int i = SETS - 1; i >= 0; i--) begin
			if (en_eff[i]) begin
				pri = 3'(i);
			end
			if (hit[i]) begin
				hit_bank = 3'(i);
			end
		end
		victim = pri;
		for (int i = SETS - 1; i >= 0; i--) begin
			if (en_eff[i] && !valid[i][cidx]) begin
				victim = 3'(i);
			end
		end
		dpar_bad = (word_q[hit_bank][35:32] ^
			{4{cache_control_reg[CTRL_WRONG_PAR]}}) !=
			byte_par(word_q[hit_bank][31:0]);
	end

	always_comb begin
		next_state = state;
		next_cur = cur;
		next_cache_control_reg = cache_control_reg;
		next_bank_en = bank_en;
		next_bank_hit = bank_hit;
		next_valid = valid;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		next_par_err = 1'b0;
		next_mem_req = mem_req;
		next_mem_cmd = mem_cmd;
		tag_we = '0;
		lo_we = '0;
		hi_we = '0;
		tag_wd = '0;
		lo_wd = '0;
		hi_wd = '0;
		next_ipr_rdata = '0;
		if (ipr.num == CTRL_REG_NUM) begin
			next_ipr_rdata = {28'h0, cache_control_reg[3:2], 1'b0,
				cache_control_reg[0]};
		end
		if (ipr.wr && ipr.num == CTRL_REG_NUM) begin
			next_cache_control_reg = {ipr.wdata[3:2], 1'b0,
				ipr.wdata[0]};
			if (ipr.wdata[CTRL_FLUSH]) begin
				next_valid = '0;
			end
		end
		case (state)
			ST_IDLE: begin
				if (req_valid) begin
					next_cur = req;
					next_state = ST_LOOK;
				end
			end
			ST_LOOK: begin
				if (in_win) begin
					next_rsp_valid = 1'b1;
					next_state = ST_IDLE;
					if (cur.addr[WIN_BANK_BIT]) begin
						next_rsp_data = {16'h0, bank_hit, en_eff};
						if (cur.write) begin
							next_bank_en = cur.wdata[7:0] & FUSE_OK;
						end
					end else if (cur.addr[11:10] == WIN_DATA) begin
						next_rsp_data = word_q[pri][31:0];
						lo_wd = {byte_par(cur.wdata), cur.wdata};
						hi_wd = lo_wd;
						if (cur.write) begin
							lo_we = cur.addr[2] ? '0 : en_eff;
							hi_we = cur.addr[2] ? en_eff : '0;
						end
					end else begin
						next_rsp_data = {valid[pri][cidx], tag_q[pri][TAG_W],
							1'b0, tag_q[pri][TAG_W-1:0], 6'h0,
							word_q[pri][35:32]};
						tag_wd = {cur.wdata[DTAG_PAR],
							cur.wdata[TAG_LSB +: TAG_W]};
						if (cur.write) begin
							tag_we = en_eff;
							for (int i = 0; i < SETS; i++) begin
								if (en_eff[i]) begin
									next_valid[i][cidx] = cur.wdata[DTAG_VALID];
								end
							end
						end
					end
				end else begin
					if (!cur.istream) begin
						next_bank_hit = cacheable ? hit : '0;
					end
					if (!cur.write && cacheable && hit != '0 && !dpar_bad) begin
						next_rsp_data = word_q[hit_bank][31:0];
						next_rsp_valid = 1'b1;
						next_state = ST_IDLE;
					end else begin
						// Write-through: refresh hit banks, then go to memory
						next_par_err = !cur.write && cacheable &&
							hit != '0 && dpar_bad;
						lo_wd = {byte_par(cur.wdata), cur.wdata};
						hi_wd = lo_wd;
						if (cur.write && cacheable) begin
							lo_we = cur.addr[2] ? '0 : hit;
							hi_we = cur.addr[2] ? hit : '0;
						end
						next_mem_req = 1'b1;
						next_mem_cmd.write = cur.write;
						next_mem_cmd.wdata = cur.wdata;
						next_mem_cmd.addr = cur.write ? cur.addr :
							{cur.addr[ADDR_W-1:OFS_W], 3'h0};
						next_state = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (mem_ack) begin
					next_mem_req = 1'b0;
					next_rsp_valid = 1'b1;
					next_state = ST_IDLE;
					if (!cur.write) begin
						next_rsp_data = cur.addr[2] ? mem_rdata[63:32] :
							mem_rdata[31:0];
						if (cacheable && en_eff != '0) begin
							tag_wd = {^ctag, ctag};
							lo_wd = {byte_par(mem_rdata[31:0]), mem_rdata[31:0]};
							hi_wd = {byte_par(mem_rdata[63:32]),
								mem_rdata[63:32]};
							tag_we[victim] = 1'b1;
							lo_we[victim] = 1'b1;
							hi_we[victim] = 1'b1;
							// Placed after the flush so a fill in that cycle wins
							next_valid[victim][cidx] = 1'b1;
						end
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_req_ready = next_state == ST_IDLE;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cur <= '0;
			cache_control_reg <= CTRL_RESET;
			bank_en <= BANK_EN_RESET;
			bank_hit <= BANK_HIT_RESET;
			valid <= '0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			par_err <= 1'b0;
			ipr_rdata <= '0;
			mem_req <= 1'b0;
			mem_cmd <= '0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			cache_control_reg <= next_cache_control_reg;
			bank_en <= next_bank_en;
			bank_hit <= next_bank_hit;
			valid <= next_valid;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			par_err <= next_par_err;
			ipr_rdata <= next_ipr_rdata;
			mem_req <= next_mem_req;
			mem_cmd <= next_mem_cmd;
		end
	end

endmodule // primary_cache

// ### shared/cache_pkg.sv
package cache_pkg;

	localparam int ADDR_W = 30;
	localparam int SETS = 8;
	localparam int ENTRIES = 128;
	localparam int IDX_W = 7;
	localparam int TAG_W = 19;
	localparam int OFS_W = 3;
	localparam int IDX_LSB = OFS_W;
	localparam int TAG_LSB = OFS_W + IDX_W;
	localparam int TAGRAM_W = TAG_W + 1;
	localparam int DATARAM_W = 36;

	localparam logic [7:0] CTRL_REG_NUM = 8'h25;
	localparam int CTRL_WRONG_PAR = 3;
	localparam int CTRL_ENABLE = 2;
	localparam int CTRL_FLUSH = 1;
	localparam int CTRL_DIAG = 0;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Diagnostic window: address bits 29:12 select it, bits 11:10 the array
	localparam logic [17:0] DIAG_PAGE = 18'h20150;
	localparam logic [1:0] WIN_TAG = 2'h0;
	localparam logic [1:0] WIN_DATA = 2'h1;
	localparam int WIN_BANK_BIT = 11;

	localparam int DTAG_VALID = 31;
	localparam int DTAG_PAR = 30;
	localparam logic [7:0] BANK_EN_RESET = 8'h00;
	localparam logic [7:0] BANK_HIT_RESET = 8'h00;
	localparam int IO_SPACE_BIT = 29;

	typedef struct packed {
		logic write;
		logic istream;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} cpu_req_t;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} mem_cmd_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] num;
		logic [31:0] wdata;
	} ipr_cmd_t;

	function automatic logic [3:0] byte_par(input logic [31:0] d);
		byte_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
	endfunction

endpackage

// ### tb/cache_asserts.sv
module cache_asserts
	import cache_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire cpu_req_t req, // Reference
	input wire logic req_valid, // Valid
	input wire logic req_ready, // Ready
	input wire logic rsp_valid, // Answer
	input wire ipr_cmd_t ipr, // Register access
	input wire logic [31:0] ipr_rdata, // Register data
	input wire logic mem_req, // Bus request
	input wire mem_cmd_t mem_cmd, // Bus cycle
	input wire logic mem_ack // Bus done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic diag;
	logic take;
	assign take = req_valid && req_ready && req.addr[29:12] == DIAG_PAGE;
	// Mirror of the diagnostic bit, needed to judge window accesses
	always_ff @(posedge clk_sys)
		if (!rst_n)
			diag <= 1'b0;
		else if (ipr.wr && ipr.num == CTRL_REG_NUM)
			diag <= ipr.wdata[CTRL_DIAG];
	chk_ctrl_zero_bits: assert property (
		ipr_rdata[31:4] == 28'h0 && !ipr_rdata[1])
		else $error("control image has unused bits set");
	chk_ctrl_write_back: assert property (
		ipr.wr && ipr.num == CTRL_REG_NUM ##1
		!ipr.wr && ipr.num == CTRL_REG_NUM
		|=> ipr_rdata[3:0] == ($past(ipr.wdata[3:0], 2) & 4'hD))
		else $error("control write not read back");
	chk_reset_clear: assert property (disable iff (1'b0)
		!rst_n |=> !rsp_valid && !mem_req && ipr_rdata == 32'h0)
		else $error("outputs not cleared by reset");
	chk_fill_aligned: assert property (
		mem_req && !mem_cmd.write |-> mem_cmd.addr[2:0] == 3'h0)
		else $error("fill not quadword aligned");
	chk_diag_bypass: assert property (
		take && !diag |-> ##2 mem_req)
		else $error("window access not sent to bus");
	chk_diag_local: assert property (
		take && diag |=> !mem_req [*2] ##0 rsp_valid)
		else $error("window access not served locally");
	chk_cycle_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
		else $error("bus cycle changed before done");
	chk_ack_answer: assert property (
		mem_req && mem_ack |=> !mem_req && rsp_valid)
		else $error("bus done not answered");
	chk_ready_busy: assert property (
		req_valid && req_ready |=> !req_ready)
		else $error("reference taken while busy");
	chk_ready_back: assert property (
		rsp_valid |-> req_ready)
		else $error("not ready when answering");
endmodule // cache_asserts

bind primary_cache cache_asserts chk_u (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.req(req),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.rsp_valid(rsp_valid),
	.ipr(ipr),
	.ipr_rdata(ipr_rdata),
	.mem_req(mem_req),
	.mem_cmd(mem_cmd),
	.mem_ack(mem_ack)
);

// ### tb/mem_model.sv
module mem_model
	import cache_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic mem_req, // Cycle request
	input wire mem_cmd_t mem_cmd, // Cycle command
	input wire logic [3:0] dly, // Extra wait cycles
	output logic mem_ack, // Cycle done
	output logic [63:0] mem_rdata // Read quadword
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [int];
	int cnt = 0;
	int cycles = 0;
	function automatic logic [31:0] pat(input logic [29:0] x);
		x[1:0] = 2'h0;
		return mem.exists(x) ? mem[x] : {x, 2'h1} ^ 32'h5A3C_96E1;
	endfunction
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 64'h0;
	end
	// Idle data lines toggle, so a stale quadword never passes
	always @(posedge clk_sys) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && cnt < dly)
			cnt <= cnt + 1;
		else if (mem_req && !mem_ack) begin
			cnt <= 0;
			mem_ack <= 1'b1;
			cycles <= cycles + 1;
			if (mem_cmd.write)
				mem[{mem_cmd.addr[29:2], 2'h0}] = mem_cmd.wdata;
			else
				mem_rdata <= {pat(mem_cmd.addr + 30'h4), pat(mem_cmd.addr)};
		end
	end
endmodule // mem_model

// ### tb/tb_primary_cache.sv
module tb_primary_cache
	import cache_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [29:0] W_B = 30'h2015_0800;
	localparam logic [29:0] W_D = 30'h2015_0408;
	localparam logic [29:0] W_T = 30'h2015_0008;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cpu_req_t req = '0;
	logic req_valid = 1'b0;
	ipr_cmd_t ipr = '{1'b0, 1'b0, 8'h25, 32'h0};
	logic [3:0] dly = 4'h0;
	logic ist = 1'b0;
	logic req_ready, rsp_valid, par_err, mem_req, mem_ack, pe;
	logic [31:0] rsp_data, ipr_rdata, rd, d;
	logic [31:0] seed = 32'hC4E4_3893;
	logic [63:0] mem_rdata;
	logic [29:0] a;
	mem_cmd_t mem_cmd;
	int fail_count = 0;
	int compares = 0;
	initial forever #4 clk_sys = ~clk_sys;
	primary_cache #(.FUSE_OK(8'h7F)) dut_u (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.req(req),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_data(rsp_data),
		.par_err(par_err),
		.ipr(ipr),
		.ipr_rdata(ipr_rdata),
		.mem_req(mem_req),
		.mem_cmd(mem_cmd),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);
	mem_model mem_u (
		.clk_sys(clk_sys),
		.mem_req(mem_req),
		.mem_cmd(mem_cmd),
		.dly(dly),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: exp %h got %h", s, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic ctrl_wr(logic [31:0] v);
		@(posedge clk_sys);
		ipr.wr <= 1'b1;
		ipr.wdata <= v;
		@(posedge clk_sys);
		ipr.wr <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("ctrl", v & 32'hD, ipr_rdata);
	endtask
	task automatic cpu(logic w, logic [29:0] x, logic [31:0] v);
		int n = 0;
		@(posedge clk_sys);
		req <= '{w, ist, x, v};
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		pe = 1'b0;
		do begin
			@(negedge clk_sys);
			pe |= par_err;
			n++;
		end while (rsp_valid !== 1'b1 && n < 99);
		rd = rsp_data;
		if (rsp_valid !== 1'b1) begin
			fail_count++;
			$display("unexpected rsp_valid: exp 1 got 0");
			give_verdict();
		end
	endtask
	task automatic rc(logic [29:0] x, logic [31:0] e);
		cpu(1'b0, x, 32'h0);
		chk("read", e, rd);
	endtask
	// Checks data against memory and, if c >= 0, the bus cycle count
	task automatic rdc(logic [29:0] x, int c);
		int c0 = mem_u.cycles;
		rc(x, mem_u.pat(x));
		if (c >= 0)
			chk("cycles", 32'(c), 32'(mem_u.cycles - c0));
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("ctrl", 32'h0, ipr_rdata);
		// A write to another register number must leave control alone
		@(posedge clk_sys);
		ipr.num <= 8'h39;
		ipr.wr <= 1'b1;
		ipr.wdata <= 32'hF;
		@(posedge clk_sys);
		ipr.wr <= 1'b0;
		@(negedge clk_sys);
		chk("other reg", 32'h0, ipr_rdata);
		@(posedge clk_sys);
		ipr.num <= CTRL_REG_NUM;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("ctrl", 32'h0, ipr_rdata);
		ctrl_wr(32'hFFFF_FFFB);
		ctrl_wr(32'h1);
		rc(W_B, 32'h0);
		cpu(1'b1, W_B, 32'hFFFF_FFFF);
		rc(W_B, 32'h7F);
		cpu(1'b1, W_D, 32'h1234_5678);
		cpu(1'b1, W_B, 32'h4);
		cpu(1'b1, W_D, 32'h9ABC_DEF0);
		cpu(1'b1, W_B, 32'h6);
		rc(W_D, 32'h1234_5678);
		cpu(1'b1, W_B, 32'hC);
		rc(W_D, 32'h9ABC_DEF0);
		d = xs() & 32'h1FFF_FC00 | 32'hC000_0000;
		cpu(1'b1, W_T, d);
		// Byte parity of data longword 9ABC_DEF0 held in bank 2 at that index is 4
		rc(W_T, d | 32'h4);
		ctrl_wr(32'h3);
		cpu(1'b1, W_B, 32'h1);
		ctrl_wr(32'h3);
		ctrl_wr(32'h4);
		a = 30'(xs() & 32'h3FF8);
		rdc(a, 1);
		rdc(a + 30'h4, 0);
		rdc(a ^ 30'h400, 1);
		rdc(a, 1);
		ctrl_wr(32'hC);
		rdc(a, 1);
		chk("parity", 32'h1, 32'(pe));
		ctrl_wr(32'h4);
		rdc(W_B, 1);
		rdc(a, 0);
		ctrl_wr(32'h5);
		rc(W_B, 32'h101);
		// An I-stream miss must leave the D-stream hit flags as they were
		ist = 1'b1;
		rdc(a ^ 30'h400, 1);
		ist = 1'b0;
		rc(W_B, 32'h101);
		ctrl_wr(32'h6);
		rdc(a, 1);
		for (int i = 0; i < 24; i++) begin
			dly <= 4'(xs());
			a = 30'(xs() & 32'h3FFC);
			if (xs() & 32'h1)
				cpu(1'b1, a, xs());
			else
				rdc(a, -1);
		end
		give_verdict();
	end
endmodule // tb_primary_cache
